// file: design/fiu_top.sv
// Purpose: frontend interrupt unit, request latches, masks and pin drive
// Assumes: all inputs synchronous to sys_clk; one clock, sync reset
// Notes:   request bits are sticky except the combined bit; source set beats software clear
`timescale 1ns/1ps

module fiu_top
  import fiu_pkg::*;
#(
  parameter int unsigned FILL_WIDTH = FILL_W
) (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // register port
  input  wire fiu_bus_req_t          bus_req,
  output logic [DATA_W-1:0]          bus_rdata,
  // frontend sources
  input  wire logic                  fill_high_status,
  input  wire logic [FILL_WIDTH-1:0] buffer_fill_count,
  input  wire logic [FILL_WIDTH-1:0] water_level,
  input  wire fiu_events_t           events,
  input  wire fiu_errors_t           errors,
  // command field state
  output logic [3:0]                 command_field,
  input  wire logic                  host_cmd_wr,
  input  wire logic [3:0]            host_cmd,
  // interrupt pin
  output logic                       irq_pin_o,
  output logic                       irq_pin_oe
);

  logic [7:0]        flags_a_q;
  logic [7:0]        flags_b_q;
  logic [7:0]        mask_a_q;
  logic [7:0]        mask_b_q;
  logic [7:0]        flags_a_d;
  logic [7:0]        flags_b_d;
  logic [NUM_A-1:0]  src_a;
  logic [NUM_B-1:0]  src_b;
  logic [4:0]        err_prev_q;
  logic              fill_low_status;
  logic              err_rise;
  logic              combined;
  logic              pin_active;
  logic              wr_a;
  logic              wr_b;

  assign wr_a = bus_req.wr && (bus_req.addr == OFS_FLAGS_A);
  assign wr_b = bus_req.wr && (bus_req.addr == OFS_FLAGS_B);

  assign fill_low_status = (buffer_fill_count <= water_level);

  // flags are levels; only a fresh error should raise the request
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      err_prev_q <= 5'h00;
    end else begin
      err_prev_q <= errors;
    end
  end
  assign err_rise = |(errors & ~err_prev_q);

  // command field tracks host writes and device-side returns to idle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      command_field <= CMD_IDLE;
    end else if (events.cmd_ended || events.cmd_unknown) begin
      command_field <= CMD_IDLE;
    end else if (host_cmd_wr) begin
      command_field <= host_cmd;
    end
  end

  // host idle writes are not a source, so they never set the request
  always_comb begin
    src_a = '0;
    src_a[6] = fill_high_status;
    src_a[5] = fill_low_status;
    src_a[4] = events.cmd_ended || events.cmd_unknown;
    src_a[3] = events.frame_sent;
    src_a[2] = events.stream_end;
    src_a[1] = err_rise;
    src_a[0] = events.frame_start;
    src_b = {events.card_sensed, events.timer_underflow};
  end

  assign combined = |(flags_a_q[NUM_A-1:0] & mask_a_q[NUM_A-1:0])
                  | |(flags_b_q[NUM_B-1:0] & mask_b_q[NUM_B-1:0]);

  // per-bit next value: write set/clear first, then sources on top
  always_comb begin
    flags_a_d = flags_a_q;
    flags_b_d = flags_b_q;
    flags_a_d[7] = 1'b0;
    flags_b_d[7] = 1'b0;
    for (int i = 0; i < NUM_A; i++) begin
      if (wr_a && bus_req.wdata[i]) begin
        flags_a_d[i] = bus_req.wdata[BIT_SET_SEL];
      end
      if (src_a[i]) begin
        flags_a_d[i] = 1'b1;
      end
    end
    for (int i = 0; i < NUM_B; i++) begin
      if (wr_b && bus_req.wdata[i]) begin
        flags_b_d[i] = bus_req.wdata[BIT_SET_SEL];
      end
      if (src_b[i]) begin
        flags_b_d[i] = 1'b1;
      end
    end
    // combined bit is a registered copy of the masked requests, one cycle behind
    flags_b_d[BIT_COMBINED] = combined;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flags_a_q <= RST_FLAGS_A;
      flags_b_q <= RST_FLAGS_B;
    end else begin
      flags_a_q <= flags_a_d;
      flags_b_q <= flags_b_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mask_a_q <= RST_MASK_A;
      mask_b_q <= RST_MASK_B;
    end else if (bus_req.wr && bus_req.addr == OFS_MASK_A) begin
      mask_a_q <= bus_req.wdata;
    end else if (bus_req.wr && bus_req.addr == OFS_MASK_B) begin
      mask_b_q <= bus_req.wdata;
    end
  end

  // read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus_rdata <= 8'h00;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        OFS_FLAGS_A: bus_rdata <= {1'b0, flags_a_q[6:0]};
        OFS_FLAGS_B: bus_rdata <= {1'b0, flags_b_q[6:0]};
        OFS_MASK_A:  bus_rdata <= mask_a_q;
        OFS_MASK_B:  bus_rdata <= mask_b_q;
        default:     bus_rdata <= 8'h00;
      endcase
    end else begin
      bus_rdata <= 8'h00;
    end
  end

  // pin uses registered combined bit and its own register, so it lags the flags by two cycles
  assign pin_active = mask_b_q[BIT_PIN_GATE] && flags_b_q[BIT_COMBINED];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_pin_o  <= 1'b0;
      irq_pin_oe <= 1'b0;
    end else if (mask_b_q[BIT_PIN_STYLE]) begin
      irq_pin_o  <= pin_active ^ mask_a_q[BIT_PIN_INVERT];
      irq_pin_oe <= 1'b1;
    end else begin
      // open drain only pulls low; a high level needs the pull-up
      irq_pin_o  <= 1'b0;
      irq_pin_oe <= ~(pin_active ^ mask_a_q[BIT_PIN_INVERT]);
    end
  end

  AST_SET_A: assert property (@(posedge sys_clk) disable iff (rst)
    wr_a && bus_req.wdata[7] && bus_req.wdata[3] |=> flags_a_q[3])
    else $error("set write did not set request");

  AST_CLR_A: assert property (@(posedge sys_clk) disable iff (rst)
    wr_a && !bus_req.wdata[7] && bus_req.wdata[4] && !src_a[4]
    |=> !flags_a_q[4])
    else $error("clear write did not clear request");

  AST_KEEP_B: assert property (@(posedge sys_clk) disable iff (rst)
    wr_b && !bus_req.wdata[2] && !src_b[2]
    |=> flags_b_q[2] == $past(flags_b_q[2]))
    else $error("unwritten request bit changed");

  AST_CLR_B: assert property (@(posedge sys_clk) disable iff (rst)
    wr_b && !bus_req.wdata[7] && bus_req.wdata[0] && !src_b[0]
    |=> !flags_b_q[0])
    else $error("second register clear failed");

  AST_SRC_WINS: assert property (@(posedge sys_clk) disable iff (rst)
    events.frame_sent |=> flags_a_q[3])
    else $error("source event lost");

  AST_LOW_FILL: assert property (@(posedge sys_clk) disable iff (rst)
    buffer_fill_count <= water_level |=> flags_a_q[5])
    else $error("low level request missed");

  AST_HOST_IDLE: assert property (@(posedge sys_clk) disable iff (rst)
    host_cmd_wr && !src_a[4] && !flags_a_q[4] && !wr_a |=> !flags_a_q[4])
    else $error("host idle write set done request");

  AST_TIMER: assert property (@(posedge sys_clk) disable iff (rst)
    events.timer_underflow[4] |=> flags_b_q[4])
    else $error("timer request missed");

  sequence s_enabled_card;
    flags_b_q[5] && mask_b_q[5];
  endsequence

  AST_COMBINED: assert property (@(posedge sys_clk) disable iff (rst)
    s_enabled_card |=> flags_b_q[BIT_COMBINED])
    else $error("combined request not raised");

  AST_GATE_OFF: assert property (@(posedge sys_clk) disable iff (rst)
    !mask_b_q[6] && !mask_a_q[7] && mask_b_q[7] |=> !irq_pin_o)
    else $error("pin active while gate off");

  AST_OPEN_DRAIN: assert property (@(posedge sys_clk) disable iff (rst)
    !mask_b_q[7] |=> !irq_pin_o)
    else $error("open drain pin drove high");

  AST_HI_FILL: assert property (@(posedge sys_clk) disable iff (rst)
    fill_high_status |=> flags_a_q[6])
    else $error("high level request missed");

  AST_HI_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
    flags_a_q[6] && !(wr_a && !bus_req.wdata[7] && bus_req.wdata[6])
    |=> flags_a_q[6])
    else $error("high level request dropped");

  AST_LO_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
    flags_a_q[5] && !(wr_a && !bus_req.wdata[7] && bus_req.wdata[5])
    |=> flags_a_q[5])
    else $error("low level request dropped");

  AST_DONE: assert property (@(posedge sys_clk) disable iff (rst)
    events.cmd_ended |=> flags_a_q[4] && command_field == CMD_IDLE)
    else $error("command end not flagged");

  AST_UNKNOWN: assert property (@(posedge sys_clk) disable iff (rst)
    events.cmd_unknown |=> flags_a_q[4] && command_field == CMD_IDLE)
    else $error("unknown command not returned to idle");

  AST_TX_DONE: assert property (@(posedge sys_clk) disable iff (rst)
    events.frame_sent |=> flags_a_q[3])
    else $error("transmit request missed");

  AST_RX_END: assert property (@(posedge sys_clk) disable iff (rst)
    events.stream_end |=> flags_a_q[2])
    else $error("receive request missed");

  AST_ERR_RISE: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(errors.integrity_fault_flag) |=> flags_a_q[1])
    else $error("error request missed");

  AST_FRM_ST: assert property (@(posedge sys_clk) disable iff (rst)
    events.frame_start |=> flags_a_q[0])
    else $error("frame start request missed");

  AST_CARD: assert property (@(posedge sys_clk) disable iff (rst)
    events.card_sensed |=> flags_b_q[5])
    else $error("card sense request missed");

  AST_SET_B: assert property (@(posedge sys_clk) disable iff (rst)
    wr_b && bus_req.wdata[7] && bus_req.wdata[1] |=> flags_b_q[1])
    else $error("second register set failed");

  AST_KEEP_A: assert property (@(posedge sys_clk) disable iff (rst)
    wr_a && !bus_req.wdata[6] && !src_a[6]
    |=> flags_a_q[6] == $past(flags_a_q[6]))
    else $error("unwritten first request bit changed");

  // no disable here: the check is about the reset itself
  AST_RST_A: assert property (@(posedge sys_clk)
    rst |=> flags_a_q == RST_FLAGS_A)
    else $error("first request register not cleared by reset");

  sequence s_enabled_first;
    |(flags_a_q[6:0] & mask_a_q[6:0]);
  endsequence

  AST_MASK_A: assert property (@(posedge sys_clk) disable iff (rst)
    s_enabled_first |=> flags_b_q[BIT_COMBINED])
    else $error("enabled first request not combined");

  AST_ALL_OFF: assert property (@(posedge sys_clk) disable iff (rst)
    !(|(flags_a_q[6:0] & mask_a_q[6:0]))
    && !(|(flags_b_q[5:0] & mask_b_q[5:0]))
    |=> !flags_b_q[BIT_COMBINED])
    else $error("combined request without enabled source");

  // pin path has two register stages: combined bit, then pin
  sequence s_pin_armed;
    mask_b_q[6] && mask_b_q[7] && !mask_a_q[7] && flags_b_q[6];
  endsequence

  AST_PIN_ON: assert property (@(posedge sys_clk) disable iff (rst)
    s_pin_armed |=> irq_pin_o)
    else $error("pin not driven for combined request");

  AST_INVERT: assert property (@(posedge sys_clk) disable iff (rst)
    mask_b_q[7] && !mask_b_q[6] && mask_a_q[7] |=> irq_pin_o)
    else $error("inverted idle pin not high");

  sequence s_od_idle;
    !mask_b_q[7] && !mask_b_q[6] && mask_a_q[7];
  endsequence

  AST_OD_REL: assert property (@(posedge sys_clk) disable iff (rst)
    s_od_idle |=> !irq_pin_oe)
    else $error("open drain idle pin not released");

  AST_PP_DRV: assert property (@(posedge sys_clk) disable iff (rst)
    mask_b_q[7] |=> irq_pin_oe)
    else $error("push-pull pin not driven");

  AST_RD_IDLE: assert property (@(posedge sys_clk) disable iff (rst)
    !bus_req.rd |=> bus_rdata == 8'h00)
    else $error("read data outside its cycle");

  AST_RD_UNMAP: assert property (@(posedge sys_clk) disable iff (rst)
    bus_req.rd && (bus_req.addr < OFS_FLAGS_A || bus_req.addr > OFS_MASK_B)
    |=> bus_rdata == 8'h00)
    else $error("unmapped read not zero");

endmodule

// file: pkg/fiu_pkg.sv
// Purpose: constants and carrier types for the frontend interrupt unit
// Assumes: byte-wide register port, printed offsets are register addresses
// Notes:   bit 7 of each request write selects set or clear
package fiu_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FILL_W = 10;

  localparam logic [7:0] OFS_FLAGS_A = 8'h06;
  localparam logic [7:0] OFS_FLAGS_B = 8'h07;
  localparam logic [7:0] OFS_MASK_A  = 8'h08;
  localparam logic [7:0] OFS_MASK_B  = 8'h09;

  localparam logic [7:0] RST_FLAGS_A = 8'h00;
  localparam logic [7:0] RST_FLAGS_B = 8'h00;
  localparam logic [7:0] RST_MASK_A  = 8'h00;
  localparam logic [7:0] RST_MASK_B  = 8'h00;

  localparam int unsigned BIT_SET_SEL    = 7;
  localparam int unsigned BIT_COMBINED   = 6;
  localparam int unsigned BIT_PIN_GATE   = 6;
  localparam int unsigned BIT_PIN_INVERT = 7;
  localparam int unsigned BIT_PIN_STYLE  = 7;
  localparam int unsigned NUM_A          = 7;
  localparam int unsigned NUM_B          = 6;

  localparam logic [3:0] CMD_IDLE = 4'h0;

  // one-cycle event pulses from the surrounding frontend
  typedef struct packed {
    logic       cmd_ended;      // running command finished on its own
    logic       cmd_unknown;    // unknown command code was started
    logic       frame_sent;     // last bit of an outgoing frame sent
    logic       stream_end;     // receiver saw end of stream
    logic       frame_start;    // start of frame or subcarrier seen
    logic       card_sensed;    // low-power card detection hit
    logic [4:0] timer_underflow;
  } fiu_events_t;

  // error flag levels; a rising edge of any raises the error request
  typedef struct packed {
    logic buffer_write_violation;
    logic buffer_overflow_flag;
    logic framing_violation_flag;
    logic empty_send_flag;
    logic integrity_fault_flag;
  } fiu_errors_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } fiu_bus_req_t;

endpackage

// file: test/fiu_host_model.sv
// Purpose: host side of the interrupt pin, with the board pull-up
// Assumes: host only senses the pin level
// Notes:   a released pin reads high, never the last driven value
`timescale 1ns/1ps

module fiu_host_model (
  // pin from the device
  input  wire logic irq_pin_o,
  input  wire logic irq_pin_oe,
  // level seen by the host
  output logic      pin_level
);
  // released open-drain floats up to the pull-up
  assign pin_level = irq_pin_oe ? irq_pin_o : 1'b1;
endmodule

// file: test/fiu_top_tb.sv
// Purpose: self-checking bench for the frontend interrupt unit
// Assumes: register port and sources driven at the rising edge
// Notes:   pin level judged through the host model pull-up
`timescale 1ns/1ps

module fiu_top_tb
  import fiu_pkg::*;
;
  logic              sys_clk;
  logic              rst;
  fiu_bus_req_t      bus_req;
  logic [DATA_W-1:0] bus_rdata;
  logic              fill_high_status;
  logic [FILL_W-1:0] buffer_fill_count;
  logic [FILL_W-1:0] water_level;
  fiu_events_t       events;
  fiu_errors_t       errors;
  logic [3:0]        command_field;
  logic              host_cmd_wr;
  logic [3:0]        host_cmd;
  logic              irq_pin_o;
  logic              irq_pin_oe;
  logic              pin_level;
  int                num_errors;
  int                n_compared;
  logic [7:0]        got;
  logic [7:0]        ex;
  logic [23:0]       reg_rows [11];
  logic [31:0]       pin_rows [7];

  fiu_top #(.FILL_WIDTH(FILL_W)) i_fiu_top (
    .sys_clk(sys_clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .fill_high_status(fill_high_status),
    .buffer_fill_count(buffer_fill_count), .water_level(water_level),
    .events(events), .errors(errors), .command_field(command_field),
    .host_cmd_wr(host_cmd_wr), .host_cmd(host_cmd),
    .irq_pin_o(irq_pin_o), .irq_pin_oe(irq_pin_oe));

  fiu_host_model i_fiu_host_model (
    .irq_pin_o(irq_pin_o), .irq_pin_oe(irq_pin_oe), .pin_level(pin_level));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk) bus_req <= {1'b1, 1'b0, a, d};
    @(posedge sys_clk) bus_req <= '0;
  endtask

  // data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk) bus_req <= {1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk) bus_req <= '0;
    #1 got = bus_rdata;
  endtask

  task automatic pulse(input logic [10:0] ev);
    @(posedge sys_clk) events <= ev;
    @(posedge sys_clk) events <= '0;
  endtask

  task automatic hcmd(input logic [3:0] c);
    @(posedge sys_clk) host_cmd_wr <= 1'b1;
    host_cmd <= c;
    @(posedge sys_clk) host_cmd_wr <= 1'b0;
  endtask

  task automatic final_report();
    if (num_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // whole run is a few hundred cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    num_errors++;
    final_report();
  end

  initial begin
    rst = 1'b1;
    bus_req = '0;
    fill_high_status = 1'b0;
    buffer_fill_count = 10'h005;
    water_level = 10'h000;
    events = '0;
    errors = '0;
    host_cmd_wr = 1'b0;
    host_cmd = 4'h0;
    num_errors = 0;
    n_compared = 0;
    reg_rows = '{24'h06FF7F, 24'h06057A, 24'h06807A, 24'h06007A, 24'h067F00,
                 24'h07BF3F, 24'h07211E, 24'h071E00, 24'h08A5A5, 24'h095A5A,
                 24'h080000};
    pin_rows = '{32'h08C00160, 32'h88C00060, 32'h00C00020, 32'h00E00160,
                 32'h88000160, 32'h08000060, 32'h08400160};
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 6; i <= 10; i++) begin
      rd(8'(i));
      chk(got, 8'h00);
    end
    foreach (reg_rows[k]) begin
      wr(reg_rows[k][23:16], reg_rows[k][15:8]);
      rd(reg_rows[k][23:16]);
      chk(got, reg_rows[k][7:0]);
    end
    wr(OFS_MASK_B, 8'h00);
    hcmd(4'h3);
    for (int i = 0; i < 11; i++) begin
      pulse(11'(1 << i));
      rd(OFS_FLAGS_A);
      ex = i >= 9 ? 8'h10 : i == 8 ? 8'h08 : i == 7 ? 8'h04 : 8'h00;
      ex = i == 6 ? 8'h01 : ex;
      chk(got, ex);
      rd(OFS_FLAGS_B);
      chk(got, i <= 5 ? 8'(1 << i) : 8'h00);
      if (i == 9) chk({4'h0, command_field}, {4'h0, CMD_IDLE});
      wr(OFS_FLAGS_A, 8'h7F);
      wr(OFS_FLAGS_B, 8'h3F);
    end
    hcmd(CMD_IDLE);
    rd(OFS_FLAGS_A);
    chk(got, 8'h00);
    for (int j = 0; j < 5; j++) begin
      @(posedge sys_clk) errors <= 5'(1 << j);
      @(posedge sys_clk) errors <= '0;
      rd(OFS_FLAGS_A);
      chk(got, 8'h02);
      wr(OFS_FLAGS_A, 8'h7F);
    end
    // level sources drop before the read to prove latching
    @(posedge sys_clk) fill_high_status <= 1'b1;
    water_level <= 10'h005;
    @(posedge sys_clk) fill_high_status <= 1'b0;
    water_level <= 10'h004;
    rd(OFS_FLAGS_A);
    chk(got, 8'h60);
    wr(OFS_FLAGS_A, 8'h7F);
    rd(OFS_FLAGS_A);
    chk(got, 8'h00);
    @(posedge sys_clk) events <= 11'h100;
    bus_req <= {1'b1, 1'b0, OFS_FLAGS_A, 8'h08};
    @(posedge sys_clk) events <= '0;
    bus_req <= '0;
    rd(OFS_FLAGS_A);
    chk(got, 8'h08);
    wr(OFS_FLAGS_B, 8'hA0);
    foreach (pin_rows[k]) begin
      wr(OFS_MASK_A, pin_rows[k][31:24]);
      wr(OFS_MASK_B, pin_rows[k][23:16]);
      rd(OFS_FLAGS_B);
      chk(got, pin_rows[k][7:0]);
      chk({7'h00, pin_level}, pin_rows[k][15:8]);
    end
    final_report();
  end
endmodule
